// >>> pld_ctrl.sv
// Purpose: register init, preload, signature and readback protection of a small pld
// Assumes: axi4-lite slave on sys_clk, next-state mask written over axi4-lite into next_q
// Notes:   configuration array modelled as a small word array
`timescale 1ns/1ps
`default_nettype none
module pld_ctrl #(
  parameter int N = pld_ctrl_pkg::NUM_OUT,
  parameter int PWRUP_CYC = pld_ctrl_pkg::PWRUP_CYCLES
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic [N-1:0] in_pin,
  input  wire logic [N-1:0] in_pin_driven,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  output logic [N-1:0]      out_pin,
  output logic [N-1:0]      out_pin_oe,
  output logic              init_done
);
  localparam int CW = $clog2(pld_ctrl_pkg::CFG_WORDS);
  localparam int PW = $clog2(PWRUP_CYC + 1);

  logic [N-1:0]  in_sync;
  logic [N-1:0]  reg_q;
  logic [N-1:0]  pol_q;
  logic [N-1:0]  oe_q;
  logic [N-1:0]  next_q;
  logic [N-1:0]  preload_q;
  logic [63:0]   sig_q;
  logic [31:0]   cfg_mem [pld_ctrl_pkg::CFG_WORDS];
  logic [CW-1:0] cfg_idx_q;
  logic          sec_q;
  logic          prog_q;
  logic [CW:0]   erase_cnt_q;
  logic [PW-1:0] pwr_cnt_q;
  logic          aw_held_q;
  logic          w_held_q;
  logic [7:0]    awaddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;
  logic          wr_fire;
  logic          pre_fire;

  pin_sync #(
    .W (N)
  ) u_sync (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clk_en     (clk_en),
    .pin_val    (in_pin),
    .pin_driven (in_pin_driven),
    .sync_q     (in_sync)
  );

  // byte-lane merge used by every writable register except cfg_idx_q and the control bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // address held until both halves arrive, either order accepted
  assign wr_fire  = aw_held_q && w_held_q && !s_axi_bvalid;
  assign pre_fire = wr_fire && (awaddr_q == pld_ctrl_pkg::CTRL_OFF) && wstrb_q[0]
                    && wdata_q[pld_ctrl_pkg::CTRL_PRE_BIT] && init_done;

  // write address and data capture
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write response; array writes outside a programming cycle and status writes are refused with slverr
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pld_ctrl_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        unique case (awaddr_q)
          pld_ctrl_pkg::CTRL_OFF, pld_ctrl_pkg::POL_OFF, pld_ctrl_pkg::OE_OFF,
          pld_ctrl_pkg::PRELOAD_OFF, pld_ctrl_pkg::SIG_LO_OFF, pld_ctrl_pkg::SIG_HI_OFF,
          pld_ctrl_pkg::CFG_IDX_OFF, pld_ctrl_pkg::NEXT_OFF:
            s_axi_bresp <= pld_ctrl_pkg::RESP_OKAY;
          pld_ctrl_pkg::CFG_DATA_OFF:
            s_axi_bresp <= prog_q ? pld_ctrl_pkg::RESP_OKAY : pld_ctrl_pkg::RESP_SLVERR;
          pld_ctrl_pkg::STATUS_OFF:
            s_axi_bresp <= pld_ctrl_pkg::RESP_SLVERR;
          default:
            s_axi_bresp <= pld_ctrl_pkg::RESP_DECERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // plain software-written registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pol_q     <= '0;
      oe_q      <= '0;
      preload_q <= '0;
      next_q    <= '0;
      cfg_idx_q <= '0;
      sig_q     <= {pld_ctrl_pkg::SIG_RST, pld_ctrl_pkg::SIG_RST};
    end else if (clk_en && wr_fire) begin
      unique case (awaddr_q)
        pld_ctrl_pkg::POL_OFF:     pol_q     <= N'(merge(32'(pol_q), wdata_q, wstrb_q));
        pld_ctrl_pkg::OE_OFF:      oe_q      <= N'(merge(32'(oe_q), wdata_q, wstrb_q));
        pld_ctrl_pkg::PRELOAD_OFF: preload_q <= N'(merge(32'(preload_q), wdata_q, wstrb_q));
        pld_ctrl_pkg::NEXT_OFF:    next_q    <= N'(merge(32'(next_q), wdata_q, wstrb_q));
        pld_ctrl_pkg::CFG_IDX_OFF: cfg_idx_q <= wdata_q[CW-1:0];
        // signature stays writable regardless of the security cell
        pld_ctrl_pkg::SIG_LO_OFF:  sig_q[31:0]  <= merge(sig_q[31:0], wdata_q, wstrb_q);
        pld_ctrl_pkg::SIG_HI_OFF:  sig_q[63:32] <= merge(sig_q[63:32], wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // programming cycle: start erases the array and the security cell first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prog_q      <= 1'b0;
      sec_q       <= 1'b0;
      erase_cnt_q <= '0;
    end else if (clk_en) begin
      if (erase_cnt_q != '0) begin
        erase_cnt_q <= erase_cnt_q - 1'b1;
      end
      if (wr_fire && awaddr_q == pld_ctrl_pkg::CTRL_OFF && wstrb_q[0]) begin
        if (wdata_q[pld_ctrl_pkg::CTRL_PROG_BIT] && !prog_q) begin
          prog_q      <= 1'b1;
          sec_q       <= 1'b0;
          erase_cnt_q <= (CW+1)'(pld_ctrl_pkg::CFG_WORDS);
        end else if (!wdata_q[pld_ctrl_pkg::CTRL_PROG_BIT] && prog_q && erase_cnt_q == '0) begin
          prog_q <= 1'b0;
          // the cell can only be set as a cycle closes; once set only reprogram clears
          if (wdata_q[pld_ctrl_pkg::CTRL_SEC_BIT]) sec_q <= 1'b1;
        end
      end
    end
  end

  // configuration array: auto-erased word by word, written only while programming
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (erase_cnt_q != '0) begin
        cfg_mem[CW'(erase_cnt_q - 1'b1)] <= 32'h0000_0000;
      end else if (wr_fire && prog_q && awaddr_q == pld_ctrl_pkg::CFG_DATA_OFF) begin
        cfg_mem[cfg_idx_q] <= merge(cfg_mem[cfg_idx_q], wdata_q, wstrb_q);
      end
    end
  end

  // power-up reset timer: registers held low until it expires
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr_cnt_q <= '0;
      init_done <= 1'b0;
    end else if (clk_en && !init_done) begin
      pwr_cnt_q <= pwr_cnt_q + 1'b1;
      if (pwr_cnt_q == PW'(PWRUP_CYC - 1)) init_done <= 1'b1;
    end
  end

  // macrocell registers: cleared, preloaded, or clocked from next-state logic
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_q <= '0;
    end else if (clk_en) begin
      if (!init_done) begin
        reg_q <= '0;
      end else if (pre_fire) begin
        reg_q <= preload_q;
      end else begin
        // next-state mixes pin inputs with present state, so preloaded values feed in
        reg_q <= (next_q & in_sync) ^ reg_q;
      end
    end
  end

  // pin drive follows polarity and enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_pin    <= '0;
      out_pin_oe <= '0;
    end else if (clk_en) begin
      out_pin    <= reg_q ^ pol_q;
      out_pin_oe <= oe_q & {N{init_done}};
    end
  end

  // read channel; signature ignores the security cell, array does not
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pld_ctrl_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= pld_ctrl_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          pld_ctrl_pkg::CTRL_OFF:    s_axi_rdata <= {30'h0, sec_q, prog_q};
          pld_ctrl_pkg::STATUS_OFF:  s_axi_rdata <= {30'h0, init_done, erase_cnt_q != '0};
          pld_ctrl_pkg::POL_OFF:     s_axi_rdata <= 32'(pol_q);
          pld_ctrl_pkg::OE_OFF:      s_axi_rdata <= 32'(oe_q);
          pld_ctrl_pkg::PRELOAD_OFF: s_axi_rdata <= 32'(reg_q);
          pld_ctrl_pkg::SIG_LO_OFF:  s_axi_rdata <= sig_q[31:0];
          pld_ctrl_pkg::SIG_HI_OFF:  s_axi_rdata <= sig_q[63:32];
          pld_ctrl_pkg::CFG_IDX_OFF: s_axi_rdata <= 32'(cfg_idx_q);
          pld_ctrl_pkg::NEXT_OFF:    s_axi_rdata <= 32'(next_q);
          pld_ctrl_pkg::CFG_DATA_OFF: begin
            if (sec_q) begin
              s_axi_rdata <= pld_ctrl_pkg::CFG_LOCKED_VAL;
              s_axi_rresp <= pld_ctrl_pkg::RESP_SLVERR;
            end else begin
              s_axi_rdata <= cfg_mem[cfg_idx_q];
            end
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pld_ctrl_pkg::RESP_DECERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // locked array read gives no data
  locked_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && s_axi_arvalid && s_axi_arready && sec_q
     && s_axi_araddr == pld_ctrl_pkg::CFG_DATA_OFF)
    |=> (s_axi_rresp == pld_ctrl_pkg::RESP_SLVERR && s_axi_rdata == 32'h0))
    else $error("protected array was read back");

  // registers stay low until timer expires
  pwrup_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    !init_done |-> reg_q == '0)
    else $error("register not cleared during power-up");

  // init within bound when clock enabled throughout
  pwrup_time_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && pwr_cnt_q == PW'(PWRUP_CYC - 1)) |=> init_done)
    else $error("power-up reset overran");

  // preload lands next cycle
  preload_take_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && pre_fire) |=> reg_q == $past(preload_q))
    else $error("preload value not loaded");

  // pin mirrors register through polarity
  pin_polarity_a: assert property (@(posedge sys_clk) disable iff (rst)
    $past(clk_en) |-> out_pin == ($past(reg_q) ^ $past(pol_q)))
    else $error("pin does not follow polarity");

  // upper signature word read ignores lock
  sig_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr == pld_ctrl_pkg::SIG_HI_OFF)
    |=> (s_axi_rresp == pld_ctrl_pkg::RESP_OKAY && s_axi_rdata == $past(sig_q[63:32])))
    else $error("signature read refused");

  // lock never falls outside a program start
  sec_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
    ($past(sec_q) && !sec_q) |-> (prog_q && erase_cnt_q != '0))
    else $error("security cleared without reprogram");

  // program start erases the whole array
  auto_erase_a: assert property (@(posedge sys_clk) disable iff (rst)
    ($rose(prog_q)) |-> erase_cnt_q == (CW+1)'(pld_ctrl_pkg::CFG_WORDS))
    else $error("program cycle did not begin with erase");
endmodule : pld_ctrl
`default_nettype wire

// >>> pld_ctrl_pkg.sv
// Purpose: shared constants for the programmable logic control block
// Assumes: 32-bit axi4-lite register access, 250 mhz sys_clk
// Notes:   offsets are byte addresses of aligned words
package pld_ctrl_pkg;
  localparam int          NUM_OUT        = 10;
  localparam int          CFG_WORDS      = 8;
  localparam int          CLK_PERIOD_PS  = 4000;
  localparam int          PWRUP_MAX_US   = 1;
  localparam int          PWRUP_CYCLES   = (PWRUP_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam logic [7:0]  CTRL_OFF       = 8'h00;
  localparam logic [7:0]  STATUS_OFF     = 8'h04;
  localparam logic [7:0]  POL_OFF        = 8'h08;
  localparam logic [7:0]  OE_OFF         = 8'h0c;
  localparam logic [7:0]  PRELOAD_OFF    = 8'h10;
  localparam logic [7:0]  SIG_LO_OFF     = 8'h14;
  localparam logic [7:0]  SIG_HI_OFF     = 8'h18;
  localparam logic [7:0]  CFG_IDX_OFF    = 8'h1c;
  localparam logic [7:0]  CFG_DATA_OFF   = 8'h20;
  localparam logic [7:0]  NEXT_OFF       = 8'h24;
  localparam int          CTRL_PROG_BIT  = 0;
  localparam int          CTRL_SEC_BIT   = 1;
  localparam int          CTRL_PRE_BIT   = 2;
  localparam logic [31:0] SIG_RST        = 32'h0000_0000;
  localparam logic [31:0] CFG_LOCKED_VAL = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
  localparam logic [1:0]  RESP_DECERR    = 2'b11;
endpackage : pld_ctrl_pkg

// >>> pin_sync.sv
// Purpose: two-stage synchroniser for pin inputs with pull-up default
// Assumes: pins are sampled on sys_clk
// Notes:   undriven pins arrive as pin_driven low and resolve to one
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] pin_val,
  input  wire logic [W-1:0] pin_driven,
  output logic      [W-1:0] sync_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] level;

  // an undriven pin reads as logic 1 through the internal pull-up
  assign level = pin_val | ~pin_driven;

  // first stage is read only by the second stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else if (clk_en) begin
      meta_q <= level;
      sync_q <= meta_q;
    end
  end
endmodule : pin_sync
`default_nettype wire

// >>> pin_drv_model.sv
// Purpose: far-side model of the system logic that drives the pins
// Assumes: pins change only just after a rising sys_clk edge
// Notes:   a released pin shows low, the opposite of the internal pull-up level
`timescale 1ns/1ps
`default_nettype none
module pin_drv_model #(
  parameter int W = pld_ctrl_pkg::NUM_OUT
) (
  input  wire logic         sys_clk,
  input  wire logic [W-1:0] want_val,
  input  wire logic [W-1:0] want_drv,
  output logic      [W-1:0] pin,
  output logic      [W-1:0] driven
);
  // released bits show low, so only the device's own pull-up can make them read one
  always @(posedge sys_clk) begin
    pin <= want_val & want_drv;
    driven <= want_drv;
  end
endmodule : pin_drv_model
`default_nettype wire

// >>> pld_register_init_and_config_protect_test.sv
// Purpose: self-checking bench for pld_ctrl over axi4-lite and the pins
// Assumes: short power-up count, 4 ns clock
// Notes:   configuration and signature model kept in bench variables
`timescale 1ns/1ps
`default_nettype none
module pld_register_init_and_config_protect_test;
  localparam int P = 4;
  localparam int LIMIT = 20000;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [9:0]  pv = 10'h000;
  logic [9:0]  pd = 10'h3ff;
  logic        clk_en = 1'b1;
  logic [3:0]  strb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, init_done;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, d, s0, s1, s2, dv;
  logic [9:0]  out_pin, oe, in_pin, in_drv, p, m, v, pb;
  logic [1:0]  r;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          seed = 32'h7723;
  int          n;
  int          cfg_m [8];
  bit          sec_m;

  pld_ctrl #(.PWRUP_CYC(P)) u_pld_ctrl (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .in_pin(in_pin), .in_pin_driven(in_drv),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .out_pin(out_pin), .out_pin_oe(oe), .init_done(init_done)
  );
  pin_drv_model u_pin_drv_model (
    .sys_clk(sys_clk), .want_val(pv), .want_drv(pd), .pin(in_pin), .driven(in_drv)
  );

  // clock stays still while power comes up, then runs freely
  initial begin
    #10;
    forever #2 sys_clk = ~sys_clk;
  end
  // hang guard counts as a failure
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // write: both channels offered together, each released at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      ta = ta | awready;
      tw = tw | wready;
    end
    while (bvalid !== 1'b1) @(posedge sys_clk);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rr);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge sys_clk);
    rready <= 1'b0;
    dat = rdata;
    rr = rresp;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] got;
    logic [1:0]  gr;
    rd(a, got, gr);
    chk("rdata", got, exp);
    chk("rresp", {30'h0, gr}, {30'h0, er});
  endtask : rdc

  // readback of word 3 as the model predicts it
  task automatic cfg_chk();
    rdc(pld_ctrl_pkg::CFG_DATA_OFF, sec_m ? 32'h0 : cfg_m[3],
        sec_m ? pld_ctrl_pkg::RESP_SLVERR : pld_ctrl_pkg::RESP_OKAY);
  endtask : cfg_chk

  // program start: waits out the automatic erase, then points at word 3
  task automatic prog();
    wr(pld_ctrl_pkg::CTRL_OFF, 32'h1, pld_ctrl_pkg::RESP_OKAY);
    do rd(pld_ctrl_pkg::STATUS_OFF, d, r); while (d[0] !== 1'b0);
    cfg_m = '{default: 0};
    sec_m = 1'b0;
    wr(pld_ctrl_pkg::CFG_IDX_OFF, 32'h3, pld_ctrl_pkg::RESP_OKAY);
  endtask : prog

  initial begin
    cfg_m = '{default: 0};
    sec_m = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    n = 0;
    while (init_done !== 1'b1) begin
      @(posedge sys_clk);
      chk("oe before init", {22'h0, oe}, 32'h0);
      n++;
    end
    chk("init bound", {31'h0, n <= P + 2}, 32'h1);
    rdc(pld_ctrl_pkg::PRELOAD_OFF, 32'h0, pld_ctrl_pkg::RESP_OKAY);
    p = $random(seed);
    m = $random(seed);
    v = $random(seed);
    pb = $random(seed);
    wr(pld_ctrl_pkg::POL_OFF, {22'h0, p}, pld_ctrl_pkg::RESP_OKAY);
    wr(pld_ctrl_pkg::OE_OFF, 32'h3ff, pld_ctrl_pkg::RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk("pins after init", {22'h0, out_pin}, {22'h0, p});
    chk("oe after init", {22'h0, oe}, 32'h3ff);
    wr(pld_ctrl_pkg::NEXT_OFF, {22'h0, m}, pld_ctrl_pkg::RESP_OKAY);
    wr(pld_ctrl_pkg::PRELOAD_OFF, {22'h0, v}, pld_ctrl_pkg::RESP_OKAY);
    wr(pld_ctrl_pkg::CTRL_OFF, 32'h4, pld_ctrl_pkg::RESP_OKAY);
    rdc(pld_ctrl_pkg::PRELOAD_OFF, {22'h0, v}, pld_ctrl_pkg::RESP_OKAY);
    chk("pins after preload", {22'h0, out_pin}, {22'h0, v ^ p});
    // one-cycle release of pb: floating pins must read as one
    @(posedge sys_clk);
    pd <= ~pb;
    @(posedge sys_clk);
    pd <= 10'h3ff;
    repeat (6) @(posedge sys_clk);
    rdc(pld_ctrl_pkg::PRELOAD_OFF, {22'h0, v ^ (m & pb)}, pld_ctrl_pkg::RESP_OKAY);
    // pins released while frozen: nothing may be sampled or toggled
    @(posedge sys_clk);
    clk_en <= 1'b0;
    pd <= ~pb;
    repeat (4) @(posedge sys_clk);
    chk("pins frozen", {22'h0, out_pin}, {22'h0, v ^ (m & pb) ^ p});
    pd <= 10'h3ff;
    @(posedge sys_clk);
    clk_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdc(pld_ctrl_pkg::PRELOAD_OFF, {22'h0, v ^ (m & pb)}, pld_ctrl_pkg::RESP_OKAY);
    s0 = $random(seed);
    s1 = $random(seed);
    wr(pld_ctrl_pkg::SIG_LO_OFF, s0, pld_ctrl_pkg::RESP_OKAY);
    wr(pld_ctrl_pkg::SIG_HI_OFF, s1, pld_ctrl_pkg::RESP_OKAY);
    // low two byte lanes only: upper half of the word must survive
    s2 = $random(seed);
    strb <= 4'h3;
    wr(pld_ctrl_pkg::SIG_LO_OFF, s2, pld_ctrl_pkg::RESP_OKAY);
    strb <= 4'hf;
    s0 = {s0[31:16], s2[15:0]};
    rdc(pld_ctrl_pkg::SIG_LO_OFF, s0, pld_ctrl_pkg::RESP_OKAY);
    rdc(pld_ctrl_pkg::SIG_HI_OFF, s1, pld_ctrl_pkg::RESP_OKAY);
    dv = $random(seed);
    wr(pld_ctrl_pkg::CFG_DATA_OFF, dv, pld_ctrl_pkg::RESP_SLVERR);
    prog();
    wr(pld_ctrl_pkg::CFG_DATA_OFF, dv, pld_ctrl_pkg::RESP_OKAY);
    cfg_m[3] = dv;
    wr(pld_ctrl_pkg::CTRL_OFF, 32'h0, pld_ctrl_pkg::RESP_OKAY);
    cfg_chk();
    prog();
    cfg_chk();
    wr(pld_ctrl_pkg::CFG_DATA_OFF, ~dv, pld_ctrl_pkg::RESP_OKAY);
    wr(pld_ctrl_pkg::CTRL_OFF, 32'h2, pld_ctrl_pkg::RESP_OKAY);
    cfg_m[3] = ~dv;
    sec_m = 1'b1;
    rdc(pld_ctrl_pkg::CTRL_OFF, 32'h2, pld_ctrl_pkg::RESP_OKAY);
    cfg_chk();
    rdc(pld_ctrl_pkg::SIG_LO_OFF, s0, pld_ctrl_pkg::RESP_OKAY);
    rdc(pld_ctrl_pkg::SIG_HI_OFF, s1, pld_ctrl_pkg::RESP_OKAY);
    prog();
    rdc(pld_ctrl_pkg::CTRL_OFF, 32'h1, pld_ctrl_pkg::RESP_OKAY);
    wr(pld_ctrl_pkg::CTRL_OFF, 32'h0, pld_ctrl_pkg::RESP_OKAY);
    cfg_chk();
    wr(pld_ctrl_pkg::STATUS_OFF, 32'h0, pld_ctrl_pkg::RESP_SLVERR);
    wr(8'h80, 32'h0, pld_ctrl_pkg::RESP_DECERR);
    rd(8'h80, d, r);
    chk("unmapped read", {30'h0, r}, {30'h0, pld_ctrl_pkg::RESP_DECERR});
    close_out();
  end
endmodule : pld_register_init_and_config_protect_test
`default_nettype wire
